/* common/pia_pkg.sv */
// Constants and types of the PHY identifier and advertisement registers
// Operation
// R1 - Identifier high register returns OUI bits 3..18 as a constant, no reset touches it.
// R2 - Identifier low register bits 15:10 return OUI bits 19..24, constant across resets.
// R3 - Identifier low register bits 3:0 return the silicon revision number.
// R4 - Advertisement writes stay pending until software reset, restart, power-up or link loss; the code applies the T4 bit at once.
// R5 - When gigabit is advertised the device sends the required next pages by itself.
// R6 - Software keeps the next page bit clear unless it has next pages of its own.
// R7 - The remote fault bit of the sent base page follows the applied remote fault bit.
// R8 - Hardware reset loads asymmetric pause and pause from the pause strap.
// R9 - The pause bit tells the partner whether the MAC implements pause.
// R10 - The 100BASE-T4 bit resets to zero on hardware reset and survives software reset.
// R11 - Forced gigabit with negotiation off still negotiates gigabit only, duplex from the bit.
// R12 - In forced gigabit the 10/100 bits and the gigabit control bits are ignored.
// R13 - Hardware reset loads both 100BASE-TX bits from strap bit one.
// R14 - The acknowledge bit always reads zero and ignores writes.
package pia_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_ID_HIGH = 6'h02;
  localparam logic [5:0] IDX_ID_LOW = 6'h03;
  localparam logic [5:0] IDX_ADVERT = 6'h04;
  localparam logic [5:0] IDX_NEG_CTRL = 6'h10;
  localparam logic [5:0] IDX_ADV_STATE = 6'h11;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_NP = 15;
  localparam int B_ACK = 14;
  localparam int B_RF = 13;
  localparam int B_ASYM = 11;
  localparam int B_PAUSE = 10;
  localparam int B_T4 = 9;
  localparam int B_FD100 = 8;
  localparam int B_HD100 = 7;
  // Bits that wait for a trigger event
  localparam logic [15:0] ADV_PEND_MASK = 16'hbd80;
  // Negotiation control register bits
  localparam int C_SWRST = 0;
  localparam int C_RESTART = 1;
  localparam int C_PDOWN = 2;
  localparam int C_ANEN = 3;
  localparam int C_SPD1000 = 4;
  localparam int C_DUPLEX = 5;
  localparam int C_GFD = 6;
  localparam int C_GHD = 7;
  localparam logic [7:0] CTRL_RST = 8'hc8;
  localparam logic [7:0] CTRL_WMASK = 8'hfc;
  // Advertisement state register bits
  localparam int S_AUTO_NP = 2;
  localparam int S_GFD = 1;
  localparam int S_GHD = 0;
  localparam logic [15:0] ADV_RST = 16'h0000;
  localparam logic [1:0] ADDR_ALIGNED = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pia_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pia_apb_rsp_t;

  typedef struct packed {
    logic [15:0] base_page;
    logic giga_fd;
    logic giga_hd;
    logic auto_next_page;
  } pia_adv_t;

endpackage

/* sim/phy_id_and_aneg_advert_regs_bench.sv */
// Self-checking bench for the identifier and advertisement register bank
module phy_id_and_aneg_advert_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pia_pkg::*;

  // Identity values, arbitrary
  localparam logic [15:0] OH = 16'h5a3c;
  localparam logic [15:0] OL = {6'h2d, 6'h13, 4'h7};
  logic pclk, presetn, ps, cs, drop, link_up, e;
  logic [15:0] rx_page;
  logic [31:0] r;
  pia_apb_req_t req;
  pia_apb_rsp_t rsp;
  pia_adv_t adv;
  int failures, comparisons;

  pia_regs #(.OUI_HIGH(OH), .OUI_LOW(OL[15:10]), .MODEL(OL[9:4]), .REVISION(OL[3:0])) uut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pause_ability_strap(ps), .negotiation_config_strap_bit1(cs),
    .link_up(link_up), .adv(adv));
  pia_link_partner lp (.pclk(pclk), .presetn(presetn), .drop(drop), .adv(adv),
    .link_up(link_up), .rx_page(rx_page));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  // One APB transfer; held until pready is seen at a rising edge, no latency assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, {16'h0000, d}};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    // Answer taken at the very edge that completes the access
    r = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk(n < 20, "no pready");
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000);
    chk(r === {16'h0000, x} && e === 1'b0, "read mismatch");
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
    chk(e === 1'b0, "write refused");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Both strap polarities, identifiers unchanged by each reset
  task automatic sc_straps();
    for (int i = 0; i < 2; i++) begin
      ps <= !i[0];
      cs <= i[0];
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      rd(8'h08, OH);
      rd(8'h0c, OL);
      rd(8'h10, {4'h0, !i[0], !i[0], 1'b0, i[0], i[0], 7'h00});
    end
  endtask

  // Each trigger in turn; the page must not move before it
  task automatic sc_pending();
    logic [15:0] v[4];
    logic [15:0] prev;
    v = '{16'h6c00, 16'h4380, 16'h3400, 16'h0a80};
    prev = 16'h0180;
    for (int k = 0; k < 4; k++) begin
      wr(8'h10, v[k]);
      rd(8'h10, v[k] & 16'hbf80);
      repeat (4) @(negedge pclk);
      chk((rx_page & 16'h3d80) === prev, "advert applied early");
      case (k)
        0: wr(8'h40, 16'h00c9);
        1: wr(8'h40, 16'h00ca);
        2: begin
          wr(8'h40, 16'h00cc);
          wr(8'h40, 16'h00c8);
        end
        default: begin
          @(posedge pclk);
          drop <= 1'b1;
          @(posedge pclk);
          drop <= 1'b0;
        end
      endcase
      repeat (4) @(negedge pclk);
      prev = v[k] & 16'h3d80;
      chk((rx_page & 16'h3f80) === (v[k] & 16'h3f80), "advert not applied");
    end
    wr(8'h10, 16'h0200);
    wr(8'h40, 16'h00c9);
    rd(8'h10, 16'h0200);
  endtask

  // Forced gigabit: duplex bit decides, ability bits ignored
  task automatic sc_forced();
    // 10/100 bits advertised first, so forcing has something to hide
    wr(8'h10, 16'h0180);
    wr(8'h40, 16'h00b0);
    wr(8'h40, 16'h00b2);
    repeat (4) @(negedge pclk);
    chk(adv.giga_fd === 1'b1 && adv.giga_hd === 1'b0 && adv.base_page[8:5] === 4'h0,
      "forced full duplex");
    chk(adv.auto_next_page === 1'b1 && adv.base_page[15] === 1'b1, "next page");
    wr(8'h40, 16'h0052);
    repeat (4) @(negedge pclk);
    chk(adv.giga_fd === 1'b0 && adv.giga_hd === 1'b1, "forced half duplex");
    rd(8'h40, 16'h0050);
    wr(8'h40, 16'h00c8);
    repeat (4) @(negedge pclk);
    chk(adv.giga_fd === 1'b1 && adv.giga_hd === 1'b1 && adv.base_page[8:7] === 2'b11,
      "forced mode not left");
  endtask

  // Unmapped and misaligned accesses are refused and change nothing
  task automatic sc_refused();
    apb(1'b0, 8'h14, 16'h0000);
    chk(e === 1'b1 && r === 32'h0, "unmapped read accepted");
    apb(1'b1, 8'h11, 16'hffff);
    chk(e === 1'b1 && r === 32'h0, "misaligned write accepted");
    rd(8'h10, 16'h0180);
  endtask

  task automatic summarize();
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Run is under two hundred cycles; this bound of 5000 cycles leaves ample margin
  initial begin
    #500000;
    failures++;
    summarize();
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    ps = 1'b0;
    cs = 1'b0;
    drop = 1'b0;
    sc_straps();
    sc_pending();
    sc_forced();
    sc_refused();
    summarize();
  end
endmodule

/* sim/pia_link_partner.sv */
// Remote link partner model: owns the copper link and takes the sent base page
module pia_link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic drop,
  input wire pia_pkg::pia_adv_t adv,
  output logic link_up,
  output logic [15:0] rx_page
);
  timeunit 1ns;
  timeprecision 1ns;
  import pia_pkg::*;

  // Link returns one cycle after a drop request; page only taken while up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_up <= 1'b0;
      rx_page <= 16'h0000;
    end else begin
      link_up <= !drop;
      if (link_up) begin
        rx_page <= adv.base_page;
      end
    end
  end
endmodule

/* src/pia_regs.sv */
// PHY identifier and copper advertisement register bank with APB slave
module pia_regs #(
  parameter logic [15:0] OUI_HIGH = 16'h1234, // arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h15, // arbitrary value
  parameter logic [5:0] MODEL = 6'h2a, // arbitrary value
  parameter logic [3:0] REVISION = 4'h1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pia_pkg::pia_apb_req_t apb_req,
  output pia_pkg::pia_apb_rsp_t apb_rsp,
  input wire logic pause_ability_strap,
  input wire logic negotiation_config_strap_bit1,
  input wire logic link_up,
  output pia_pkg::pia_adv_t adv
);
  import pia_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] pend;
    logic [15:0] act;
    logic link_q;
    logic strap_done;
    pia_apb_rsp_t rsp;
    pia_adv_t adv;
  } pia_state_t;

  pia_state_t s;
  pia_state_t next_s;
  logic [5:0] idx;
  logic setup;
  logic wr;
  logic apply;
  logic forced;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [15:0] rd_word(input logic [5:0] i, input pia_state_t st);
    logic [15:0] w;
    w = 16'h0000;
    case (i)
      IDX_ID_HIGH: w = OUI_HIGH; // see R1
      IDX_ID_LOW: w = {OUI_LOW, MODEL, REVISION}; // see R2 see R3
      IDX_ADVERT: w = st.pend;
      IDX_NEG_CTRL: w = {8'h00, st.ctrl};
      IDX_ADV_STATE: w = {st.act[15:7], 4'h0, st.adv.auto_next_page, st.adv.giga_fd,
                          st.adv.giga_hd};
      default: w = 16'h0000;
    endcase
    return w;
  endfunction

  function automatic logic hit(input logic [5:0] i);
    return (i == IDX_ID_HIGH) || (i == IDX_ID_LOW) || (i == IDX_ADVERT) ||
           (i == IDX_NEG_CTRL) || (i == IDX_ADV_STATE);
  endfunction

  assign idx = apb_req.paddr[7:2];
  assign setup = apb_req.psel & ~apb_req.penable;
  // Write lands only at the completing access edge
  assign wr = apb_req.psel & apb_req.penable & s.rsp.pready & apb_req.pwrite &
              ~s.rsp.pslverr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    apply = 1'b0;
    // Answer one cycle after setup, so access lasts one cycle
    next_s.rsp.pready = setup;
    if (setup) begin
      next_s.rsp.pslverr = ~hit(idx) | (apb_req.paddr[1:0] != ADDR_ALIGNED);
      next_s.rsp.prdata = {16'h0000, rd_word(idx, s)};
      // Refused accesses return zero data, whatever the index decodes to
      if (next_s.rsp.pslverr) begin
        next_s.rsp.prdata = '0;
      end
    end
    // Control bits; reset and restart are strobes, never stored
    if (wr && idx == IDX_NEG_CTRL) begin
      next_s.ctrl = apb_req.pwdata[7:0] & CTRL_WMASK;
      // see R4: each of these releases the pending word
      if (apb_req.pwdata[C_SWRST] | apb_req.pwdata[C_RESTART]) begin
        apply = 1'b1;
      end
      if (s.ctrl[C_PDOWN] & ~apb_req.pwdata[C_PDOWN]) begin
        apply = 1'b1;
      end
    end
    // Loss of link also releases the pending word
    next_s.link_q = link_up;
    if (s.link_q & ~link_up) begin
      apply = 1'b1; // see R4
    end
    if (wr && idx == IDX_ADVERT) begin
      // Ack is never stored, so it reads zero; see R14
      next_s.pend = apb_req.pwdata[15:0] & ADV_PEND_MASK;
      next_s.pend[B_T4] = apb_req.pwdata[B_T4];
      // T4 is not held back and a software reset leaves it alone; see R10
      next_s.act[B_T4] = apb_req.pwdata[B_T4];
    end
    if (apply) begin
      // Pending bits move over together; see R4
      next_s.act = (next_s.pend & ADV_PEND_MASK) | (next_s.act & ~ADV_PEND_MASK);
    end
    // Straps are caught once, on the first edge after reset release
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.pend[B_ASYM] = pause_ability_strap; // see R8
      next_s.pend[B_PAUSE] = pause_ability_strap; // see R8 see R9
      next_s.pend[B_FD100] = negotiation_config_strap_bit1; // see R13
      next_s.pend[B_HD100] = negotiation_config_strap_bit1; // see R13
      next_s.act = next_s.pend;
    end
    // Transmitted page built from applied and control state
    forced = ~next_s.ctrl[C_ANEN] & next_s.ctrl[C_SPD1000];
    next_s.adv.base_page = next_s.act & ~(16'h0001 << B_ACK); // see R7
    if (forced) begin
      // Gigabit only; 10/100 and gigabit control bits ignored; see R11 see R12
      next_s.adv.base_page[B_FD100] = 1'b0;
      next_s.adv.base_page[B_HD100] = 1'b0;
      next_s.adv.giga_fd = next_s.ctrl[C_DUPLEX];
      next_s.adv.giga_hd = ~next_s.ctrl[C_DUPLEX];
    end else begin
      next_s.adv.giga_fd = next_s.ctrl[C_GFD];
      next_s.adv.giga_hd = next_s.ctrl[C_GHD];
    end
    // Gigabit needs next pages; the block sends them itself; see R5
    next_s.adv.auto_next_page = next_s.adv.giga_fd | next_s.adv.giga_hd;
    next_s.adv.base_page[B_NP] = next_s.act[B_NP] | next_s.adv.auto_next_page;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.pend <= ADV_RST; // see R10
      s.act <= ADV_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign apb_rsp = s.rsp;
  assign adv = s.adv;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_id_high_const: assert property ( // see R1
    setup && idx == IDX_ID_HIGH |=> apb_rsp.pready && apb_rsp.prdata[15:0] == OUI_HIGH)
    else $error("identifier high read wrong");

  chk_id_low_oui: assert property ( // see R2
    setup && idx == IDX_ID_LOW |=> apb_rsp.prdata[15:10] == OUI_LOW)
    else $error("identifier low oui bits wrong");

  chk_revision_field: assert property ( // see R3
    setup && idx == IDX_ID_LOW |=> apb_rsp.prdata[3:0] == REVISION)
    else $error("revision field wrong");

  chk_pending_hold: assert property ( // see R4
    wr && idx == IDX_ADVERT && !apply && s.strap_done |=> $stable(s.act & ADV_PEND_MASK))
    else $error("advert applied without trigger");

  chk_link_apply: assert property ( // see R4
    s.strap_done && s.link_q && !link_up |=> s.act[B_PAUSE] == $past(next_s.pend[B_PAUSE]))
    else $error("link loss did not apply advert");

  chk_auto_next_page: assert property ( // see R5
    adv.giga_fd || adv.giga_hd |-> adv.base_page[B_NP] && adv.auto_next_page)
    else $error("gigabit advertised without next page");

  chk_rf_in_page: assert property ( // see R7
    s.strap_done |-> adv.base_page[B_RF] == s.act[B_RF])
    else $error("remote fault bit not in page");

  chk_strap_load: assert property ( // see R8 see R13
    $rose(s.strap_done) |-> s.act[B_PAUSE] == $past(pause_ability_strap) &&
      s.act[B_ASYM] == $past(pause_ability_strap) &&
      s.act[B_FD100] == $past(negotiation_config_strap_bit1) && !s.act[B_T4])
    else $error("strap load wrong");

  chk_forced_giga: assert property ( // see R11 see R12
    !s.ctrl[C_ANEN] && s.ctrl[C_SPD1000] |-> adv.giga_fd == s.ctrl[C_DUPLEX] &&
      adv.giga_hd != s.ctrl[C_DUPLEX] && !adv.base_page[B_FD100] && !adv.base_page[B_HD100])
    else $error("forced gigabit advert wrong");

  chk_ack_zero: assert property ( // see R14
    !s.pend[B_ACK] && !adv.base_page[B_ACK])
    else $error("acknowledge bit not zero");

  // ----------------------------------------------------------------
  // Bus, trigger and field checks
  // ----------------------------------------------------------------
  chk_ready_after_setup: assert property (
    setup |=> apb_rsp.pready)
    else $error("no answer after setup");

  chk_ready_one_cycle: assert property (
    apb_rsp.pready |-> $past(setup))
    else $error("answer without setup");

  chk_err_misaligned: assert property (
    setup && apb_req.paddr[1:0] != ADDR_ALIGNED |=> apb_rsp.pslverr)
    else $error("misaligned access not refused");

  chk_refused_data: assert property (
    apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h00000000)
    else $error("refused access returned data");

  chk_upper_half_zero: assert property (
    apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");

  chk_refused_write: assert property ( // see R4
    apb_req.psel && apb_req.penable && apb_rsp.pready && apb_rsp.pslverr && s.strap_done
      |=> $stable(s.pend) && $stable(s.ctrl))
    else $error("refused write changed a register");

  chk_strobe_zero: assert property ( // see R4
    !s.ctrl[C_SWRST] && !s.ctrl[C_RESTART])
    else $error("reset or restart strobe stored");

  chk_ctrl_write: assert property ( // see R4
    wr && idx == IDX_NEG_CTRL |=> s.ctrl == ($past(apb_req.pwdata[7:0]) & CTRL_WMASK))
    else $error("control write not stored");

  chk_restart_apply: assert property ( // see R4
    wr && idx == IDX_NEG_CTRL && (apb_req.pwdata[C_SWRST] || apb_req.pwdata[C_RESTART])
      |=> (s.act & ADV_PEND_MASK) == ($past(s.pend) & ADV_PEND_MASK))
    else $error("reset or restart did not apply advert");

  chk_pdown_exit: assert property ( // see R4
    wr && idx == IDX_NEG_CTRL && s.ctrl[C_PDOWN] && !apb_req.pwdata[C_PDOWN]
      |=> (s.act & ADV_PEND_MASK) == ($past(s.pend) & ADV_PEND_MASK))
    else $error("power-up did not apply advert");

  chk_no_trigger_hold: assert property ( // see R4
    s.strap_done && !(s.link_q && !link_up) && !(wr && idx == IDX_NEG_CTRL)
      |=> $stable(s.act & ADV_PEND_MASK))
    else $error("applied advert moved without trigger");

  chk_link_pend_keep: assert property ( // see R4
    s.strap_done && s.link_q && !link_up && !(wr && idx == IDX_ADVERT) |=> $stable(s.pend))
    else $error("link loss changed pending advert");

  chk_np_in_page: assert property ( // see R5
    s.strap_done |-> adv.base_page[B_NP] == (s.act[B_NP] || adv.auto_next_page))
    else $error("next page bit wrong in page");

  chk_pause_in_page: assert property ( // see R9
    s.strap_done |-> adv.base_page[B_PAUSE] == s.act[B_PAUSE] &&
      adv.base_page[B_ASYM] == s.act[B_ASYM])
    else $error("pause bits not in page");

  chk_strap_pause: assert property ( // see R8
    $rose(s.strap_done) |-> s.pend[B_PAUSE] == $past(pause_ability_strap) &&
      s.pend[B_ASYM] == $past(pause_ability_strap))
    else $error("pause strap not loaded");

  chk_strap_duplex: assert property ( // see R13
    $rose(s.strap_done) |-> s.act[B_HD100] == $past(negotiation_config_strap_bit1) &&
      s.pend[B_FD100] == $past(negotiation_config_strap_bit1))
    else $error("duplex strap not loaded");

  chk_t4_immediate: assert property ( // see R10
    wr && idx == IDX_ADVERT |=> s.act[B_T4] == $past(apb_req.pwdata[B_T4]))
    else $error("T4 bit not applied at once");

  chk_t4_retained: assert property ( // see R10
    wr && idx == IDX_NEG_CTRL |=> $stable(s.act[B_T4]) && $stable(s.pend[B_T4]))
    else $error("T4 bit lost on control write");

  chk_t4_in_page: assert property ( // see R10
    s.strap_done |-> adv.base_page[B_T4] == s.act[B_T4])
    else $error("T4 bit not in page");

  chk_normal_giga: assert property ( // see R12
    s.strap_done && (s.ctrl[C_ANEN] || !s.ctrl[C_SPD1000]) |->
      adv.giga_fd == s.ctrl[C_GFD] && adv.giga_hd == s.ctrl[C_GHD] &&
      adv.base_page[B_FD100:B_HD100] == s.act[B_FD100:B_HD100])
    else $error("ability bits not honoured outside forced mode");

  chk_ack_read_zero: assert property ( // see R14
    setup && idx == IDX_ADVERT |=> !apb_rsp.prdata[B_ACK])
    else $error("acknowledge bit read as one");

  chk_pend_reserved: assert property ( // see R14
    (s.pend & ~(ADV_PEND_MASK | (16'h0001 << B_T4))) == 16'h0000)
    else $error("unstored advert bit set");

  cov_apply_restart: cover property (wr && idx == IDX_NEG_CTRL && apply);
  cov_link_loss: cover property (s.link_q && !link_up);
  cov_forced: cover property (!s.ctrl[C_ANEN] && s.ctrl[C_SPD1000]);
  cov_bad_addr: cover property (apb_rsp.pready && apb_rsp.pslverr);
  cov_pdown_exit: cover property (
    wr && idx == IDX_NEG_CTRL && s.ctrl[C_PDOWN] && !apb_req.pwdata[C_PDOWN]);

endmodule
